/* File: design/split_mode_dual_timer_ctrl.sv */
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module split_mode_dual_timer_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        debug_halt,
  input  wire logic [5:0]  port_out,
  output logic      [5:0]  waveform_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0]                       control_r;
  logic [7:0]                       out_enable_r;
  logic [7:0]                       out_value_r;
  logic                             split_r;
  split_timer_pkg::command_t        command_r;
  logic [7:0]                       irq_enable_r;
  logic [7:0]                       irq_flags_r;
  logic                             debug_run_r;
  logic [7:0]                       counter_r [2];
  logic [7:0]                       period_r  [2];
  logic [7:0]                       compare_r [2][split_timer_pkg::CHANNELS];

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [5:0] index;
  logic       aligned;
  logic       setup;
  logic       wr_en;
  logic [7:0] wbyte;
  logic       is_compare;
  logic [2:0] cmp_off;

  assign index      = paddr[7:2];
  assign aligned    = (paddr[1:0] == 2'h0);
  assign setup      = psel & ~penable;
  // Writes land only at the completing access edge
  assign wr_en      = psel & penable & pready & pwrite & ~pslverr;
  assign wbyte      = pwdata[7:0];
  assign is_compare = (index >= split_timer_pkg::IDX_COMPARE_BASE) &&
                      (index <= split_timer_pkg::IDX_COMPARE_LAST);
  assign cmp_off    = 3'(index - split_timer_pkg::IDX_COMPARE_BASE);

  function automatic logic wr_at(input logic en, input logic [5:0] idx,
                                 input logic [5:0] target);
    wr_at = en && (idx == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  logic enabled;
  logic target_ok;
  logic do_restart;
  logic do_hard_reset;

  assign enabled       = control_r[split_timer_pkg::CTRL_ENABLE_BIT];
  // Reserved targets 1 and 2 never qualify a command
  assign target_ok     = (command_r.target == split_timer_pkg::TARGET_BOTH);
  assign do_restart    = target_ok && (command_r.cmd == split_timer_pkg::CMD_RESTART);
  // Hard reset is refused while the timer runs
  assign do_hard_reset = target_ok && (command_r.cmd == split_timer_pkg::CMD_RESET)
                         && !enabled;

  ////////////////////////////////////////////////////////////////////////////
  // Count qualification
  logic tick;
  logic step [2];
  logic floor_hit [2];
  logic [7:0] counter_nxt [2];

  // Debug break freezes counting unless debug run is set
  assign tick = enabled && !(debug_halt && !debug_run_r);

  generate
    for (genvar h = 0; h < 2; h++)
    begin : g_half
      logic wr_counter;
      assign wr_counter = wr_at(wr_en, index,
                                h == 0 ? split_timer_pkg::IDX_LOW_COUNTER
                                       : split_timer_pkg::IDX_HIGH_COUNTER);
      // Split mode runs halves alone; otherwise high steps on low wrap
      if (h == 0)
      begin : g_low
        assign step[h] = tick;
      end
      else
      begin : g_high
        assign step[h] = tick && (split_r || counter_r[0] == 8'h00);
      end
      // Floor is the cycle the value becomes zero
      assign floor_hit[h] = step[h] && !wr_counter && !do_hard_reset && !do_restart
                            && (counter_r[h] == 8'h01);

      always_comb
      begin
        // Bus write outranks every hardware update of the counter
        if (wr_counter)
          counter_nxt[h] = wbyte;
        else if (do_hard_reset)
          counter_nxt[h] = split_timer_pkg::RESET_ZERO;
        else if (do_restart)
          counter_nxt[h] = period_r[h];
        else if (step[h])
          counter_nxt[h] = (counter_r[h] == 8'h00) ? period_r[h] : 8'(counter_r[h] - 8'h01);
        else
          counter_nxt[h] = counter_r[h];
      end

      // Counter storage
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          counter_r[h] <= split_timer_pkg::RESET_ZERO;
        else
          counter_r[h] <= counter_nxt[h];
      end

      // Period and compare storage, restored by hard reset
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          period_r[h] <= split_timer_pkg::RESET_PERIOD;
          for (int c = 0; c < split_timer_pkg::CHANNELS; c++)
            compare_r[h][c] <= split_timer_pkg::RESET_ZERO;
        end
        else if (do_hard_reset)
        begin
          period_r[h] <= split_timer_pkg::RESET_PERIOD;
          for (int c = 0; c < split_timer_pkg::CHANNELS; c++)
            compare_r[h][c] <= split_timer_pkg::RESET_ZERO;
        end
        else
        begin
          if (wr_at(wr_en, index, h == 0 ? split_timer_pkg::IDX_LOW_PERIOD
                                         : split_timer_pkg::IDX_HIGH_PERIOD))
            period_r[h] <= wbyte;
          for (int c = 0; c < split_timer_pkg::CHANNELS; c++)
            if (wr_en && is_compare && cmp_off == 3'(2 * c + h))
              compare_r[h][c] <= wbyte;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Flag set sources
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  always_comb
  begin
    flag_set = 8'h00;
    flag_set[split_timer_pkg::FLAG_LOW_UNF]  = floor_hit[0];
    flag_set[split_timer_pkg::FLAG_HIGH_UNF] = floor_hit[1];
    // Low-half compare match is watched in every mode, running or not
    for (int c = 0; c < split_timer_pkg::CHANNELS; c++)
      flag_set[split_timer_pkg::FLAG_LOW_CMP0 + c] =
        (counter_r[0] == compare_r[0][c]);
  end

  // Write one clears; zeros leave a flag alone
  assign flag_clr = wr_at(wr_en, index, split_timer_pkg::IDX_IRQ_FLAGS) ? wbyte : 8'h00;

  // Sticky flags; a set in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_flags_r <= split_timer_pkg::RESET_ZERO;
    else
      irq_flags_r <= ((irq_flags_r & ~flag_clr) | flag_set)
                     & split_timer_pkg::IRQ_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command register; executes the cycle after the write, then the command field self-clears while the target stays
  logic [3:0] cmd_bits;
  assign cmd_bits = {command_r.cmd, command_r.target};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      command_r <= '0;
    else if (wr_at(wr_en, index, split_timer_pkg::IDX_COMMAND_SET))
      command_r <= split_timer_pkg::command_t'(cmd_bits | wbyte[3:0]);
    else if (wr_at(wr_en, index, split_timer_pkg::IDX_COMMAND_CLEAR))
      command_r <= split_timer_pkg::command_t'(cmd_bits & ~wbyte[3:0]);
    else
      command_r.cmd <= split_timer_pkg::CMD_NONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_r    <= split_timer_pkg::RESET_ZERO;
      out_enable_r <= split_timer_pkg::RESET_ZERO;
      out_value_r  <= split_timer_pkg::RESET_ZERO;
      split_r      <= 1'b0;
      irq_enable_r <= split_timer_pkg::RESET_ZERO;
      debug_run_r  <= 1'b0;
    end
    else
    begin
      if (wr_at(wr_en, index, split_timer_pkg::IDX_CONTROL))
        control_r <= wbyte & split_timer_pkg::CTRL_MASK;
      if (wr_at(wr_en, index, split_timer_pkg::IDX_OUT_ENABLE))
        out_enable_r <= wbyte & split_timer_pkg::PIN_MASK;
      if (wr_at(wr_en, index, split_timer_pkg::IDX_OUT_VALUE))
        out_value_r <= wbyte & split_timer_pkg::PIN_MASK;
      if (wr_at(wr_en, index, split_timer_pkg::IDX_SPLIT_SELECT))
        split_r <= wbyte[split_timer_pkg::SPLIT_BIT];
      if (wr_at(wr_en, index, split_timer_pkg::IDX_IRQ_ENABLE))
        irq_enable_r <= wbyte & split_timer_pkg::IRQ_MASK;
      if (wr_at(wr_en, index, split_timer_pkg::IDX_DEBUG_CONTROL))
        debug_run_r <= wbyte[split_timer_pkg::DEBUG_RUN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveform outputs, one per compare channel of each half
  logic [5:0] pin_nxt;
  logic       wave_mode;
  assign wave_mode = control_r[split_timer_pkg::CTRL_WAVE_BIT];

  generate
    for (genvar p = 0; p < 6; p++)
    begin : g_pin
      localparam int HALF = p / split_timer_pkg::CHANNELS;
      localparam int CH   = p % split_timer_pkg::CHANNELS;
      localparam int BIT  = HALF * split_timer_pkg::HIGH_PIN_BASE + CH;
      logic level;
      // Stopped timer lets software force the level
      assign level = enabled ? (counter_r[HALF] <= compare_r[HALF][CH])
                             : out_value_r[BIT];
      // Port value wins unless waveform mode and the enable are both set
      assign pin_nxt[p] = (wave_mode && out_enable_r[BIT]) ? level : port_out[p];
    end
  endgenerate

  // Registered pins keep glitches off the pads
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      waveform_pin <= 6'h00;
    else
      waveform_pin <= pin_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [7:0] rd_byte;
  logic       mapped;

  always_comb
  begin
    rd_byte = 8'h00;
    mapped  = aligned;
    unique case (index)
      split_timer_pkg::IDX_CONTROL:       rd_byte = control_r;
      split_timer_pkg::IDX_OUT_ENABLE:    rd_byte = out_enable_r;
      split_timer_pkg::IDX_OUT_VALUE:     rd_byte = out_value_r;
      split_timer_pkg::IDX_SPLIT_SELECT:  rd_byte = {7'h00, split_r};
      // Command bits never read back
      split_timer_pkg::IDX_COMMAND_CLEAR,
      split_timer_pkg::IDX_COMMAND_SET:   rd_byte = {6'h00, command_r.target};
      split_timer_pkg::IDX_IRQ_ENABLE:    rd_byte = irq_enable_r;
      split_timer_pkg::IDX_IRQ_FLAGS:     rd_byte = irq_flags_r;
      split_timer_pkg::IDX_DEBUG_CONTROL: rd_byte = {7'h00, debug_run_r};
      split_timer_pkg::IDX_LOW_COUNTER:   rd_byte = counter_r[0];
      split_timer_pkg::IDX_HIGH_COUNTER:  rd_byte = counter_r[1];
      split_timer_pkg::IDX_LOW_PERIOD:    rd_byte = period_r[0];
      split_timer_pkg::IDX_HIGH_PERIOD:   rd_byte = period_r[1];
      default:
      begin
        if (is_compare)
          rd_byte = compare_r[cmp_off[0]][cmp_off[2:1]];
        else
          mapped = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: no wait states, data captured at the setup edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite && mapped)
        prdata <= {24'h00_0000, rd_byte};
      else if (setup)
        prdata <= 32'h0000_0000;
    end
  end

endmodule

/* File: design/split_timer_pkg.sv */
package split_timer_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONTROL       = 6'h00;
  localparam logic [5:0] IDX_OUT_ENABLE    = 6'h01;
  localparam logic [5:0] IDX_OUT_VALUE     = 6'h02;
  localparam logic [5:0] IDX_SPLIT_SELECT  = 6'h03;
  localparam logic [5:0] IDX_COMMAND_CLEAR = 6'h04;
  localparam logic [5:0] IDX_COMMAND_SET   = 6'h05;
  localparam logic [5:0] IDX_IRQ_ENABLE    = 6'h0a;
  localparam logic [5:0] IDX_IRQ_FLAGS     = 6'h0b;
  localparam logic [5:0] IDX_DEBUG_CONTROL = 6'h0e;
  localparam logic [5:0] IDX_LOW_COUNTER   = 6'h20;
  localparam logic [5:0] IDX_HIGH_COUNTER  = 6'h21;
  localparam logic [5:0] IDX_LOW_PERIOD    = 6'h26;
  localparam logic [5:0] IDX_HIGH_PERIOD   = 6'h27;
  localparam logic [5:0] IDX_COMPARE_BASE  = 6'h28;
  localparam logic [5:0] IDX_COMPARE_LAST  = 6'h2d;

  // Field positions and channel count
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_WAVE_BIT    = 1;
  localparam int SPLIT_BIT        = 0;
  localparam int DEBUG_RUN_BIT    = 0;
  localparam int FLAG_LOW_UNF     = 0;
  localparam int FLAG_HIGH_UNF    = 1;
  localparam int FLAG_LOW_CMP0    = 4;
  localparam int CHANNELS         = 3;
  localparam int HIGH_PIN_BASE    = 4;

  // Masks of implemented bits
  localparam logic [7:0] IRQ_MASK   = 8'h73;
  localparam logic [7:0] PIN_MASK   = 8'h77;
  localparam logic [7:0] CTRL_MASK  = 8'h03;

  // Reset values
  localparam logic [7:0] RESET_ZERO   = 8'h00;
  localparam logic [7:0] RESET_PERIOD = 8'hff;

  // Command and target field encodings
  localparam logic [1:0] CMD_NONE    = 2'h0;
  localparam logic [1:0] CMD_RESTART = 2'h2;
  localparam logic [1:0] CMD_RESET   = 2'h3;
  localparam logic [1:0] TARGET_BOTH = 2'h3;

  // Command and target held between a set or clear write and its execution
  typedef struct packed {
    logic [1:0] cmd;
    logic [1:0] target;
  } command_t;

endpackage

/* File: verification/split_timer_assertions.sv */
`timescale 1ns/1ps
module split_timer_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // Bus phases that the properties are built from
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence read_s;
    psel && penable && pready && !pwrite;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Handshake timing, zero wait states
  ready_no_wait_a: assert property (setup_s |=> pready && penable)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  err_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr without pready or with data");
  misalign_err_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  // Read-back shapes of the documented registers
  cmd_reads_zero_a: assert property (
    read_s and (paddr[7:3] == 5'h02) |-> prdata[31:2] == 30'h0 && !pslverr)
    else $error("command bits read back nonzero");
  irq_en_bits_a: assert property (
    read_s and (paddr == 8'h28) |-> (prdata & 32'hffffff8c) == 32'h0)
    else $error("irq enable unimplemented bits set");
  split_bit_a: assert property (
    read_s and (paddr == 8'h0c) |-> prdata[31:1] == 31'h0)
    else $error("split select extra bits set");
  flag_bits_a: assert property (
    read_s and (paddr == 8'h2c) |-> (prdata & 32'hffffff8c) == 32'h0)
    else $error("irq flags unimplemented bits set");
endmodule

bind split_mode_dual_timer_ctrl split_timer_checker i_split_timer_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* File: verification/split_mode_dual_timer_ctrl_tb.sv */
`timescale 1ns/1ps
module split_mode_dual_timer_ctrl_tb;
  logic        pclk       = 1'b0;
  logic        presetn    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic        debug_halt = 1'b0;
  logic [5:0]  port_out   = 6'h2a;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  waveform_pin;
  logic [31:0] rd;
  logic        err;
  int          miscompares = 0;
  int          n_compared  = 0;
  int          cycles      = 0;
  localparam logic [5:0] I_CTL = split_timer_pkg::IDX_CONTROL;
  localparam logic [5:0] I_CCLR = split_timer_pkg::IDX_COMMAND_CLEAR;
  localparam logic [5:0] I_CSET = split_timer_pkg::IDX_COMMAND_SET;
  localparam logic [5:0] I_FLG = split_timer_pkg::IDX_IRQ_FLAGS;
  localparam logic [5:0] I_DBG = split_timer_pkg::IDX_DEBUG_CONTROL;
  localparam logic [5:0] I_CNT = split_timer_pkg::IDX_LOW_COUNTER;
  localparam logic [5:0] I_PER = split_timer_pkg::IDX_LOW_PERIOD;

  split_mode_dual_timer_ctrl i_split_mode_dual_timer_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_halt(debug_halt), .port_out(port_out), .waveform_pin(waveform_pin));

  // Clock and hang guard; a stuck handshake ends the run here
  always #50 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares = miscompares + 1;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the idle edge at the end keeps drivers race free
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer and data are taken only at the rising edge that sees pready
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'b00}, {24'h0, d});
  endtask

  task automatic rc(input logic [5:0] i, input logic [7:0] e);
    apb(1'b0, {i, 2'b00}, 32'h0);
    chk(rd, {24'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    // Pin register loads at the edge just passed; look once it has settled
    @(negedge pclk);
    chk({26'h0, waveform_pin}, 32'h2a);
    @(posedge pclk);
    rc(split_timer_pkg::IDX_SPLIT_SELECT, 8'h00);
    rc(split_timer_pkg::IDX_IRQ_ENABLE, 8'h00);
    rc(I_DBG, 8'h00);
    rc(I_CNT, 8'h00);
    rc(I_FLG, 8'h70);
  endtask

  task automatic t_rw;
    wr(split_timer_pkg::IDX_SPLIT_SELECT, 8'hff);
    rc(split_timer_pkg::IDX_SPLIT_SELECT, 8'h01);
    wr(split_timer_pkg::IDX_IRQ_ENABLE, 8'hff);
    rc(split_timer_pkg::IDX_IRQ_ENABLE, 8'h73);
    wr(I_DBG, 8'hff);
    rc(I_DBG, 8'h01);
    wr(I_DBG, 8'h00);
  endtask

  // Each channel matches once, then the counter moves away before the clear
  task automatic t_flags;
    for (int n = 0; n < 3; n++)
      wr(split_timer_pkg::IDX_COMPARE_BASE + 6'(2 * n), 8'(16 * (n + 1)));
    for (int n = 0; n < 3; n++)
    begin
      wr(I_CNT, 8'h40);
      wr(I_FLG, 8'h70);
      rc(I_FLG, 8'h00);
      wr(I_CNT, 8'(16 * (n + 1)));
      wr(I_CNT, 8'h40);
      wr(I_FLG, 8'h00);
      rc(I_FLG, 8'(8'h10 << n));
    end
    wr(I_FLG, 8'h70);
    rc(I_FLG, 8'h00);
  endtask

  task automatic t_count;
    wr(I_PER, 8'h05);
    wr(I_CNT, 8'h03);
    wr(split_timer_pkg::IDX_HIGH_COUNTER, 8'h02);
    wr(I_FLG, 8'hff);
    wr(I_CTL, 8'h01);
    repeat (4) @(posedge pclk);
    // Writes while counting; one count follows before the read samples
    wr(I_CNT, 8'h80);
    rc(I_CNT, 8'h7f);
    wr(split_timer_pkg::IDX_HIGH_COUNTER, 8'h80);
    rc(split_timer_pkg::IDX_HIGH_COUNTER, 8'h7f);
    wr(I_CTL, 8'h00);
    rc(I_FLG, 8'h03);
    // Cascade mode: high steps only on the edge where low sits at zero
    wr(split_timer_pkg::IDX_SPLIT_SELECT, 8'h00);
    wr(I_CNT, 8'h02);
    wr(split_timer_pkg::IDX_HIGH_COUNTER, 8'h50);
    wr(I_CTL, 8'h01);
    wr(I_CTL, 8'h00);
    rc(split_timer_pkg::IDX_HIGH_COUNTER, 8'h4f);
    rc(I_CNT, 8'h05);
    wr(split_timer_pkg::IDX_SPLIT_SELECT, 8'h01);
  endtask

  // Halted break freezes counting; hard reset ignored while enabled
  task automatic t_debug;
    wr(I_FLG, 8'hff);
    debug_halt <= 1'b1;
    wr(I_CNT, 8'h02);
    wr(I_CTL, 8'h01);
    repeat (8) @(posedge pclk);
    rc(I_CNT, 8'h02);
    wr(I_CSET, 8'h0f);
    rc(I_CNT, 8'h02);
    wr(I_CCLR, 8'h0f);
    wr(I_DBG, 8'h01);
    repeat (4) @(posedge pclk);
    wr(I_CTL, 8'h00);
    rc(I_FLG, 8'h01);
    debug_halt <= 1'b0;
    wr(I_DBG, 8'h00);
  endtask

  task automatic t_cmd;
    wr(I_CSET, 8'h0f);
    rc(I_CSET, 8'h03);
    rc(I_CNT, 8'h00);
    rc(I_PER, 8'hff);
    wr(I_CCLR, 8'h01);
    rc(I_CCLR, 8'h02);
    wr(I_CCLR, 8'h03);
    wr(I_PER, 8'h05);
    wr(I_CNT, 8'h40);
    wr(I_CSET, 8'h08);
    rc(I_CNT, 8'h40);
    wr(I_CSET, 8'h09);
    rc(I_CNT, 8'h40);
    wr(I_CSET, 8'h06);
    rc(I_CNT, 8'h40);
    wr(I_CSET, 8'h08);
    rc(I_CNT, 8'h05);
    wr(I_CCLR, 8'h0f);
  endtask

  task automatic t_pins;
    wr(I_CTL, 8'h02);
    wr(split_timer_pkg::IDX_OUT_ENABLE, 8'h77);
    wr(split_timer_pkg::IDX_OUT_VALUE, 8'h35);
    @(negedge pclk);
    chk({26'h0, waveform_pin}, 32'h1d);
    @(posedge pclk);
    wr(split_timer_pkg::IDX_OUT_ENABLE, 8'h00);
    @(negedge pclk);
    chk({26'h0, waveform_pin}, 32'h2a);
    @(posedge pclk);
  endtask

  task automatic t_err;
    apb(1'b1, 8'h18, 32'hff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h0d, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    rc(split_timer_pkg::IDX_SPLIT_SELECT, 8'h01);
  endtask

  task automatic summarize;
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_rw();
    t_flags();
    t_count();
    t_debug();
    t_cmd();
    t_pins();
    t_err();
    summarize();
  end
endmodule
